// ===== rtl/usbed_map.vh
// Purpose: offsets, field positions and reset values of the endpoint descriptor block
// Assumes: byte addresses on the function's memory-mapped register port
// Notes: definitions only
`ifndef USBED_MAP_VH
`define USBED_MAP_VH
`define USBED_OFF_IN3_PG0 8'hC4
`define USBED_OFF_IN3_PG1 8'hC8
`define USBED_OFF_IN3_SPR 8'hCC
`define USBED_OFF_IN4_CTL 8'hD0
`define USBED_OFF_IN4_PG0 8'hD4
`define USBED_OFF_IN4_PG1 8'hD8
`define USBED_OFF_IN4_SPR 8'hDC
`define USBED_OFF_CTL_PIO 8'hE0
`define USBED_OFF_OUT_PIO 8'hE4
`define USBED_OFF_IN_PIO 8'hE8
`define USBED_RST_WORD 32'h00000000
`define USBED_B_TERR 0
`define USBED_B_BABL 1
`define USBED_B_SHRT 2
`define USBED_B_ACT 3
`define USBED_B_CAT 4
`define USBED_B_IOC 5
`define USBED_B_IDX 6
`define USBED_B_ASYNC 7
`define USBED_B_TOG 8
`define USBED_C_TOG 31
`define USBED_C_IOC 15
`define USBED_C_SETUP 12
`define USBED_C_DIR 11
`define USBED_C_DMA1 3
`define USBED_C_CNT_LSB 16
`define USBED_C_CNT_MSB 28
`define USBED_C_CNT_MAX 13'h1000
`define USBED_MASK_BULK_PIO 32'hFFFF01FF
`define USBED_MASK_CTL 32'h9FFF880F
`endif

// ===== rtl/usbed_descriptors.v
// Purpose: transfer descriptor registers for bulk IN sets 3 and 4 and the PIO descriptors
// Assumes: simple register port on clk_sys; controller engine reports events as pulses
// Notes: events from the engine win over software writes in the same cycle
//
// Overview of operation
// - start address is 20-bit selected page joined with 12-bit current offset
// - bulk transfer starts with DATA0 or DATA1 as initial toggle field says; in3_pid_data1 always gives DATA0 here
// - bulk OUT auto sync copies final toggle into next valid descriptor
// - buffer pointer index picks page 0 or page 1; in3 address always uses page 0 here
// - interrupt-on-complete raises interrupt on completion, babble or short packet
// - concatenate chains next descriptor, taking only its page data
// - descriptor processed only while its activate bit is one
// - short and babble flags set on detection; read-only in bulk IN
// - transaction error flag set on any error, never interrupts alone
// - DMA descriptors writable only when fake attach or host attached
// - PIO descriptors writable when fake attach, attached or PIO enable
// - control byte count lies in bits 28 to 16, at most 4096
// - control transfer starts with DATA0 or DATA1 per bit 31
// - control interrupt on data or setup completion, short or babble
// - new setup packet sets write-one-to-clear flag, data in next two words
// - control direction bit: 0 host out, 1 host in
// - control bit marks endpoint for the DMA engine first
// - device flags short and babble in host OUT control transfers
// - scratch field read-write in DMA descriptors, read-only in PIO ones
`timescale 1ns/1ps
`include "usbed_map.vh"
module usbed_descriptors (
    input wire clk_sys, // 25 MHz system clock
    input wire rst_b, // async reset, active low
    input wire reg_wr, // register write strobe
    input wire reg_rd, // register read strobe
    input wire [7:0] reg_addr, // byte address
    input wire [31:0] reg_wdata, // write data
    input wire [3:0] reg_be, // byte enables
    output reg [31:0] reg_rdata, // read data, valid cycle after reg_rd
    input wire fake_attach, // fake attach enable control bit
    input wire host_attached, // function plugged to a host
    input wire pio_enable, // PIO enable control bit
    input wire [2:0] ev_sel, // descriptor targeted: 0 in3,1 in4,2 ctl,3 bulk out pio,4 in pio
    input wire ev_done, // transfer complete pulse
    input wire ev_short, // short packet pulse
    input wire ev_babble, // babble pulse
    input wire ev_error, // transaction error pulse
    input wire ev_setup, // new setup packet pulse
    input wire ev_final_tog, // final toggle at completion
    output reg irq, // one-cycle interrupt request
    output reg [31:0] in3_addr, // start buffer address bulk in 3
    output reg [31:0] in4_addr, // start buffer address bulk in 4
    output reg in3_pid_data1, // bulk in 3 starts with DATA1
    output reg in4_pid_data1, // bulk in 4 starts with DATA1
    output reg ctl_pid_data1, // control starts with DATA1
    output reg ctl_host_in, // control direction host in
    output reg ctl_dma_first, // endpoint for DMA engine first
    output reg [12:0] ctl_count, // control byte count, clipped at 4096
    output reg [3:0] desc_active // active: in4, ctl dma-first bit, bulk out pio, bulk in pio
);
    reg [31:0] in3_pg0, in3_pg1, in3_spr, in4_ctl, in4_pg0, in4_pg1, in4_spr;
    reg [31:0] ctl_pio, out_pio, in_pio;
    reg fa_s1, fa_s2, ha_s1, ha_s2, pe_s1, pe_s2;
    wire dma_wok = fa_s2 | ha_s2;
    wire pio_wok = fa_s2 | ha_s2 | pe_s2;
    wire [31:0] bem = {{8{reg_be[3]}}, {8{reg_be[2]}}, {8{reg_be[1]}}, {8{reg_be[0]}}};
    wire wr_dma = reg_wr & dma_wok;
    wire wr_pio = reg_wr & pio_wok;
    wire ev_any = ev_done | ev_short | ev_babble;
    wire ev_in3 = (ev_sel == 3'h0);
    wire ev_in4 = (ev_sel == 3'h1);
    wire ev_ctl = (ev_sel == 3'h2);
    wire ev_out = (ev_sel == 3'h3);
    wire ev_inp = (ev_sel == 3'h4);
    // bulk in descriptors keep status bits 2:1 read-only
    wire [31:0] in_wmask = bem & 32'hFFFFFFF9;
    wire [31:0] pio_wmask = bem & `USBED_MASK_BULK_PIO;
    // bulk in pio descriptor: scratch and status bits 2:1 both read-only
    wire [31:0] inp_wmask = pio_wmask & in_wmask;
    wire [31:0] ctl_wmask = bem & `USBED_MASK_CTL & ~(32'h1 << `USBED_C_SETUP);
    reg [31:0] next_in4_ctl, next_ctl_pio, next_out_pio, next_in_pio;
    reg next_irq;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fa_s1 <= 1'b0;
            fa_s2 <= 1'b0;
            ha_s1 <= 1'b0;
            ha_s2 <= 1'b0;
            pe_s1 <= 1'b0;
            pe_s2 <= 1'b0;
        end else begin
            fa_s1 <= fake_attach;
            fa_s2 <= fa_s1;
            ha_s1 <= host_attached;
            ha_s2 <= ha_s1;
            pe_s1 <= pio_enable;
            pe_s2 <= pe_s1;
        end
    end

    always @* begin
        next_in4_ctl = in4_ctl;
        next_ctl_pio = ctl_pio;
        next_out_pio = out_pio;
        next_in_pio = in_pio;
        next_irq = 1'b0;
        if (wr_dma && reg_addr == `USBED_OFF_IN4_CTL) begin
            next_in4_ctl = (in4_ctl & ~in_wmask) | (reg_wdata & in_wmask);
        end
        if (wr_pio && reg_addr == `USBED_OFF_CTL_PIO) begin
            next_ctl_pio = (ctl_pio & ~ctl_wmask) | (reg_wdata & ctl_wmask);
            if (reg_be[1] && reg_wdata[`USBED_C_SETUP]) begin
                next_ctl_pio[`USBED_C_SETUP] = 1'b0;
            end
        end
        if (wr_pio && reg_addr == `USBED_OFF_OUT_PIO) begin
            next_out_pio = (out_pio & ~pio_wmask) | (reg_wdata & pio_wmask);
        end
        if (wr_pio && reg_addr == `USBED_OFF_IN_PIO) begin
            next_in_pio = (in_pio & ~inp_wmask) | (reg_wdata & inp_wmask);
        end
        // hardware events, applied after writes so a set beats a clear
        if (ev_in4 && in4_ctl[`USBED_B_ACT]) begin
            if (ev_short) next_in4_ctl[`USBED_B_SHRT] = 1'b1;
            if (ev_babble) next_in4_ctl[`USBED_B_BABL] = 1'b1;
            if (ev_error | ev_babble) next_in4_ctl[`USBED_B_TERR] = 1'b1;
            if (ev_any && in4_ctl[`USBED_B_IOC]) next_irq = 1'b1;
            if (ev_done && !in4_ctl[`USBED_B_CAT]) next_in4_ctl[`USBED_B_ACT] = 1'b0;
        end
        if (ev_in3 && ev_done && in4_ctl[`USBED_B_ACT]) begin
            // chained: in4 keeps only its page words, so a chain bit in3 needs nothing more
        end
        if (ev_ctl) begin
            if (ev_setup) begin
                next_ctl_pio[`USBED_C_SETUP] = 1'b1;
                if (ctl_pio[`USBED_C_IOC]) next_irq = 1'b1;
            end
            if (ev_short && !ctl_pio[`USBED_C_DIR]) next_ctl_pio[`USBED_B_SHRT] = 1'b1;
            if (ev_babble && !ctl_pio[`USBED_C_DIR]) next_ctl_pio[`USBED_B_BABL] = 1'b1;
            if (ev_error | ev_babble) next_ctl_pio[`USBED_B_TERR] = 1'b1;
            if (ev_any && ctl_pio[`USBED_C_IOC]) next_irq = 1'b1;
        end
        if (ev_out && out_pio[`USBED_B_ACT]) begin
            if (ev_short) next_out_pio[`USBED_B_SHRT] = 1'b1;
            if (ev_babble) next_out_pio[`USBED_B_BABL] = 1'b1;
            if (ev_error | ev_babble) next_out_pio[`USBED_B_TERR] = 1'b1;
            if (ev_any && out_pio[`USBED_B_IOC]) next_irq = 1'b1;
            if (ev_done) begin
                next_out_pio[`USBED_B_ACT] = out_pio[`USBED_B_CAT];
                if (out_pio[`USBED_B_ASYNC] && in_pio[`USBED_B_ACT]) begin
                    next_in_pio[`USBED_B_TOG] = ev_final_tog;
                end
            end
        end
        if (ev_inp && in_pio[`USBED_B_ACT]) begin
            if (ev_short) next_in_pio[`USBED_B_SHRT] = 1'b1;
            if (ev_babble) next_in_pio[`USBED_B_BABL] = 1'b1;
            if (ev_error | ev_babble) next_in_pio[`USBED_B_TERR] = 1'b1;
            if (ev_any && in_pio[`USBED_B_IOC]) next_irq = 1'b1;
            if (ev_done) next_in_pio[`USBED_B_ACT] = in_pio[`USBED_B_CAT];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            in3_pg0 <= `USBED_RST_WORD;
            in3_pg1 <= `USBED_RST_WORD;
            in3_spr <= `USBED_RST_WORD;
            in4_ctl <= `USBED_RST_WORD;
            in4_pg0 <= `USBED_RST_WORD;
            in4_pg1 <= `USBED_RST_WORD;
            in4_spr <= `USBED_RST_WORD;
            ctl_pio <= `USBED_RST_WORD;
            out_pio <= `USBED_RST_WORD;
            in_pio <= `USBED_RST_WORD;
            irq <= 1'b0;
        end else begin
            if (wr_dma && reg_addr == `USBED_OFF_IN3_PG0) begin
                in3_pg0 <= (in3_pg0 & ~bem) | (reg_wdata & bem);
            end
            if (wr_dma && reg_addr == `USBED_OFF_IN3_PG1) begin
                in3_pg1 <= (in3_pg1 & ~(bem & 32'hFFFFF000)) | (reg_wdata & bem & 32'hFFFFF000);
            end
            if (wr_dma && reg_addr == `USBED_OFF_IN3_SPR) begin
                in3_spr <= (in3_spr & ~bem) | (reg_wdata & bem);
            end
            if (wr_dma && reg_addr == `USBED_OFF_IN4_PG0) begin
                in4_pg0 <= (in4_pg0 & ~bem) | (reg_wdata & bem);
            end
            if (wr_dma && reg_addr == `USBED_OFF_IN4_PG1) begin
                in4_pg1 <= (in4_pg1 & ~(bem & 32'hFFFFF000)) | (reg_wdata & bem & 32'hFFFFF000);
            end
            if (wr_dma && reg_addr == `USBED_OFF_IN4_SPR) begin
                in4_spr <= (in4_spr & ~bem) | (reg_wdata & bem);
            end
            in4_ctl <= next_in4_ctl;
            ctl_pio <= next_ctl_pio;
            out_pio <= next_out_pio;
            in_pio <= next_in_pio;
            irq <= next_irq;
        end
    end

    // read port and derived outputs
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h00000000;
            in3_addr <= 32'h00000000;
            in4_addr <= 32'h00000000;
            in3_pid_data1 <= 1'b0;
            in4_pid_data1 <= 1'b0;
            ctl_pid_data1 <= 1'b0;
            ctl_host_in <= 1'b0;
            ctl_dma_first <= 1'b0;
            ctl_count <= 13'h0000;
            desc_active <= 4'h0;
        end else begin
            if (reg_rd) begin
                case (reg_addr)
                    `USBED_OFF_IN3_PG0: reg_rdata <= in3_pg0;
                    `USBED_OFF_IN3_PG1: reg_rdata <= in3_pg1;
                    `USBED_OFF_IN3_SPR: reg_rdata <= in3_spr;
                    `USBED_OFF_IN4_CTL: reg_rdata <= in4_ctl;
                    `USBED_OFF_IN4_PG0: reg_rdata <= in4_pg0;
                    `USBED_OFF_IN4_PG1: reg_rdata <= in4_pg1;
                    `USBED_OFF_IN4_SPR: reg_rdata <= in4_spr;
                    `USBED_OFF_CTL_PIO: reg_rdata <= ctl_pio;
                    `USBED_OFF_OUT_PIO: reg_rdata <= out_pio;
                    `USBED_OFF_IN_PIO: reg_rdata <= in_pio;
                    default: reg_rdata <= 32'h00000000;
                endcase
            end
            // in3 control word lies outside this block; page 0 used for its address
            in3_addr <= in3_pg0;
            in4_addr <= {(in4_ctl[`USBED_B_IDX] ? in4_pg1[31:12] : in4_pg0[31:12]),
                         in4_pg0[11:0]};
            in3_pid_data1 <= 1'b0;
            in4_pid_data1 <= in4_ctl[`USBED_B_TOG];
            ctl_pid_data1 <= ctl_pio[`USBED_C_TOG];
            ctl_host_in <= ctl_pio[`USBED_C_DIR];
            ctl_dma_first <= ctl_pio[`USBED_C_DMA1];
            ctl_count <= (ctl_pio[`USBED_C_CNT_MSB:`USBED_C_CNT_LSB] > `USBED_C_CNT_MAX) ?
                         `USBED_C_CNT_MAX : ctl_pio[`USBED_C_CNT_MSB:`USBED_C_CNT_LSB];
            desc_active <= {in_pio[`USBED_B_ACT], out_pio[`USBED_B_ACT],
                            ctl_pio[`USBED_C_DMA1], in4_ctl[`USBED_B_ACT]};
        end
    end
endmodule

// ===== verification/usbed_asserts.sv
// Purpose: temporal checks on the descriptor block ports
// Assumes: one clock domain, async active-low reset
// Notes: bound into every usbed_descriptors instance
`timescale 1ns/1ps
module usbed_asserts (
    input wire clk_sys, // clock
    input wire rst_b, // reset, active low
    input wire reg_wr, // write strobe
    input wire reg_rd, // read strobe
    input wire [7:0] reg_addr, // byte address
    input wire [31:0] reg_rdata, // read data
    input wire ev_done, // completion
    input wire ev_short, // short packet
    input wire ev_babble, // babble
    input wire ev_error, // transaction error
    input wire ev_setup, // setup packet
    input wire irq, // interrupt pulse
    input wire ctl_host_in, // control direction
    input wire [12:0] ctl_count, // control count
    input wire [3:0] desc_active // active flags
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire cause = ev_done | ev_short | ev_babble | ev_setup;
    a_irq_has_cause: assert property (irq |-> $past(cause))
        else $error("irq without a completion event");
    a_error_alone: assert property (ev_error && !cause |=> !irq)
        else $error("irq from error alone");
    a_rdata_holds: assert property (
        !$past(reg_rd) && !$past(reg_rd, 2) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (
        reg_rd && reg_addr < 8'hC4 |-> ##[1:2] reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_count_max: assert property (ctl_count <= 13'h1000)
        else $error("control count above 4096");
    a_active_by_write: assert property (
        |(desc_active & ~$past(desc_active)) |-> $past(reg_wr, 2))
        else $error("descriptor activated without a write");
    a_dir_by_write: assert property (
        $changed(ctl_host_in) |-> $past(reg_wr, 2))
        else $error("direction moved without a write");
    a_count_by_write: assert property (
        $changed(ctl_count) |-> $past(reg_wr, 2))
        else $error("count moved without a write");
endmodule
bind usbed_descriptors usbed_asserts u_chk (.clk_sys, .rst_b, .reg_wr, .reg_rd, .reg_addr,
    .reg_rdata, .ev_done, .ev_short, .ev_babble, .ev_error, .ev_setup, .irq, .ctl_host_in,
    .ctl_count, .desc_active);

// ===== verification/usbed_engine_model.sv
// Purpose: controller engine stand-in reporting transfer events
// Assumes: pulses launched 1 ns after the rising edge
// Notes: one burst per call; toggle level inverted once stale
`timescale 1ns/1ps
module usbed_engine_model (
    input wire clk_sys, // clock
    output reg [2:0] ev_sel, // target descriptor
    output reg ev_done, // completion
    output reg ev_short, // short packet
    output reg ev_babble, // babble
    output reg ev_error, // transaction error
    output reg ev_setup, // setup packet
    output reg ev_final_tog // final toggle
);
    initial {ev_sel, ev_done, ev_short, ev_babble, ev_error, ev_setup, ev_final_tog} = 9'h0;
    // kind is {setup, error, babble, short, done}
    task fire(input [2:0] sel, input [4:0] kind, input tog);
        begin
            @(posedge clk_sys);
            #1;
            ev_sel = sel;
            {ev_setup, ev_error, ev_babble, ev_short, ev_done} = kind;
            ev_final_tog = tog;
            @(posedge clk_sys);
            #1;
            {ev_setup, ev_error, ev_babble, ev_short, ev_done} = 5'h0;
            ev_final_tog = ~tog;
        end
    endtask
endmodule

// ===== verification/tb_top.sv
// Purpose: self-checking bench for the descriptor registers
// Assumes: inputs change 1 ns after the rising edge
// Notes: engine events come from usbed_engine_model
`timescale 1ns/1ps
module tb_top;
    reg clk_sys = 1'b0;
    reg rst_b = 1'b0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] reg_addr = 8'h00;
    reg [31:0] reg_wdata = 32'h0;
    reg [3:0] reg_be = 4'hF;
    reg fake_attach = 1'b0;
    reg host_attached = 1'b0;
    reg pio_enable = 1'b0;
    wire [31:0] reg_rdata, in3_addr, in4_addr;
    wire [2:0] ev_sel;
    wire ev_done, ev_short, ev_babble, ev_error, ev_setup, ev_final_tog, irq;
    wire in3_pid_data1, in4_pid_data1, ctl_pid_data1, ctl_host_in, ctl_dma_first;
    wire [12:0] ctl_count;
    wire [3:0] desc_active;
    integer n_fail = 0;
    integer n_checks = 0;
    always #20 clk_sys = ~clk_sys;
    usbed_descriptors uut (.clk_sys, .rst_b, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_be,
        .reg_rdata, .fake_attach, .host_attached, .pio_enable, .ev_sel, .ev_done, .ev_short,
        .ev_babble, .ev_error, .ev_setup, .ev_final_tog, .irq, .in3_addr, .in4_addr,
        .in3_pid_data1, .in4_pid_data1, .ctl_pid_data1, .ctl_host_in, .ctl_dma_first,
        .ctl_count, .desc_active);
    usbed_engine_model eng (.clk_sys, .ev_sel, .ev_done, .ev_short, .ev_babble, .ev_error,
        .ev_setup, .ev_final_tog);
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            cyc(1);
            reg_wr = 1'b1;
            reg_addr = a;
            reg_wdata = d;
            cyc(1);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [31:0] exp);
        begin
            cyc(1);
            reg_rd = 1'b1;
            reg_addr = a;
            cyc(1);
            reg_rd = 1'b0;
            cyc(1);
            chk(reg_rdata, exp);
        end
    endtask
    task t_reset;
        reg [7:0] a;
        begin
            for (a = 8'hC4; a != 8'hEC; a = a + 8'h04)
                rd(a, 32'h0);
            rd(8'h40, 32'h0);
            $display("reset values done");
        end
    endtask
    task t_refuse;
        begin
            wr(8'hD0, 32'h00000008);
            rd(8'hD0, 32'h0);
            pio_enable = 1'b1;
            cyc(3);
            wr(8'hE4, 32'h0000FE08);
            rd(8'hE4, 32'h00000008);
            wr(8'hD0, 32'h00000008);
            rd(8'hD0, 32'h0);
            chk({28'h0, desc_active}, 32'h4);
            $display("write permission done");
        end
    endtask
    task t_bulk;
        begin
            fake_attach = 1'b1;
            cyc(3);
            wr(8'hD4, 32'h12345ABC);
            wr(8'hD8, 32'hFEDCBFFF);
            wr(8'hD0, 32'h00407F6E);
            rd(8'hD8, 32'hFEDCB000);
            rd(8'hD0, 32'h00407F68);
            chk(in4_addr, 32'hFEDCBABC);
            chk({31'h0, in4_pid_data1}, 32'h1);
            chk({28'h0, desc_active}, 32'h5);
            $display("bulk setup done");
        end
    endtask
    task t_events;
        begin
            eng.fire(3'h1, 5'b00010, 1'b0);
            chk({31'h0, irq}, 32'h1);
            rd(8'hD0, 32'h00407F6C);
            eng.fire(3'h1, 5'b01000, 1'b0);
            chk({31'h0, irq}, 32'h0);
            rd(8'hD0, 32'h00407F6D);
            eng.fire(3'h1, 5'b00100, 1'b0);
            chk({31'h0, irq}, 32'h1);
            rd(8'hD0, 32'h00407F6F);
            eng.fire(3'h1, 5'b00001, 1'b1);
            chk({31'h0, irq}, 32'h1);
            rd(8'hD0, 32'h00407F67);
            chk({28'h0, desc_active}, 32'h4);
            $display("bulk events done");
        end
    endtask
    task t_ctl;
        begin
            wr(8'hE0, 32'hFFFFFFFF);
            rd(8'hE0, 32'h9FFF880F);
            chk({19'h0, ctl_count}, 32'h1000);
            chk({29'h0, ctl_pid_data1, ctl_host_in, ctl_dma_first}, 32'h7);
            chk({31'h0, ctl_dma_first}, 32'h1);
            eng.fire(3'h2, 5'b10000, 1'b0);
            chk({31'h0, irq}, 32'h1);
            rd(8'hE0, 32'h9FFF980F);
            wr(8'hE0, 32'h00001000);
            rd(8'hE0, 32'h0);
            wr(8'hE0, 32'h00008000);
            eng.fire(3'h2, 5'b00010, 1'b0);
            chk({31'h0, irq}, 32'h1);
            rd(8'hE0, 32'h00008004);
            $display("control descriptor done");
        end
    endtask
    // host attach alone opens the dma words; set 3 page words and spares
    task t_pages;
        begin
            fake_attach = 1'b0;
            host_attached = 1'b1;
            cyc(3);
            wr(8'hC4, 32'h13579BDF);
            wr(8'hC8, 32'h2468ACE1);
            wr(8'hCC, 32'hA5A5A5A5);
            wr(8'hDC, 32'h5A5A5A5A);
            rd(8'hC8, 32'h2468A000);
            rd(8'hCC, 32'hA5A5A5A5);
            rd(8'hDC, 32'h5A5A5A5A);
            chk(in3_addr, 32'h13579BDF);
            chk({31'h0, in3_pid_data1}, 32'h0);
            $display("page words done");
        end
    endtask
    // pio chain, toggle sync, byte lanes and a setup packet racing its clear
    task t_pio;
        begin
            wr(8'hE4, 32'h000000B8);
            wr(8'hE8, 32'h0000000E);
            rd(8'hE8, 32'h00000008);
            eng.fire(3'h3, 5'b00001, 1'b1);
            chk({31'h0, irq}, 32'h1);
            rd(8'hE8, 32'h00000108);
            rd(8'hE4, 32'h000000B8);
            eng.fire(3'h4, 5'b00100, 1'b0);
            chk({31'h0, irq}, 32'h0);
            rd(8'hE8, 32'h0000010B);
            eng.fire(3'h4, 5'b00001, 1'b0);
            eng.fire(3'h4, 5'b00010, 1'b0);
            rd(8'hE8, 32'h00000103);
            chk({28'h0, desc_active}, 32'h4);
            reg_be = 4'h1;
            wr(8'hE4, 32'hFFFFFFFF);
            reg_be = 4'hF;
            rd(8'hE4, 32'h000000FF);
            fork
                eng.fire(3'h2, 5'b10000, 1'b0);
                wr(8'hE0, 32'h00001000);
            join
            rd(8'hE0, 32'h00001000);
            $display("pio descriptors done");
        end
    endtask
    // mid-run reset: everything back to zero, permits resynchronised
    task t_rerun;
        begin
            rst_b = 1'b0;
            cyc(2);
            rst_b = 1'b1;
            wr(8'hCC, 32'hFFFFFFFF);
            rd(8'hCC, 32'h0);
            rd(8'hE4, 32'h0);
            rd(8'hE8, 32'h0);
            chk({28'h0, desc_active}, 32'h0);
            chk(in3_addr, 32'h0);
            $display("second reset done");
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d failures %0d", n_checks, n_fail);
            if (n_fail == 0 && n_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    // run needs under 1000 cycles; allow five times that
    initial begin
        #200000;
        n_fail = n_fail + 1;
        finish_test;
    end
    initial begin
        cyc(12);
        rst_b = 1'b1;
        t_reset;
        t_refuse;
        t_bulk;
        t_events;
        t_ctl;
        t_pages;
        t_pio;
        t_rerun;
        finish_test;
    end
endmodule
